// >>> gppc_map.svh
// What this block does
// - Pins are grouped into eight-pin ports, 78 pins in all.
// - Each pin takes one of eight drive modes, analog to weak drive.
// - Each pin selects a CMOS or an LVTTL input threshold.
// - Hold freezes every pad output and setting until it is released.
// - Each pin selects a fast or a slow output edge rate.
// - During reset every pin is disabled with its buffers off.
// - A per-pin matrix picks software or a peripheral as pin source.
// - Software writes output data and reads back the pin levels.
// - Only enabled pins flag; a port's flags make one request line.
`ifndef GPPC_MAP_SVH
`define GPPC_MAP_SVH
`define GPPC_NUM_PINS 78
`define GPPC_NUM_PORTS 10
// Word index inside a port window, byte address = port*64 + index*4
`define GPPC_IDX_OUT 4'h0
`define GPPC_IDX_IN 4'h1
`define GPPC_IDX_MODE 4'h2
`define GPPC_IDX_THR 4'h3
`define GPPC_IDX_SLEW 4'h4
`define GPPC_IDX_SEL 4'h5
`define GPPC_IDX_EDGE 4'h6
`define GPPC_IDX_IEN 4'h7
`define GPPC_IDX_PEND 4'h8
// Global window at byte 0x800
`define GPPC_GLB_BIT 11
`define GPPC_IDX_HOLD 4'h0
`define GPPC_IDX_STAT 4'h1
`define GPPC_IDX_MASK 4'h2
`define GPPC_RST_MODE 3'h0
`define GPPC_RST_SEL 2'h0
`define GPPC_RST_EDGE 2'h1
`endif

// >>> gppc_pkg.sv
package gppc_pkg;
  typedef enum logic [2:0] {
    GPPC_ANALOG = 3'h0,
    GPPC_INPUT = 3'h1,
    GPPC_WKUP_STDN = 3'h2,
    GPPC_STUP_WKDN = 3'h3,
    GPPC_OD_LOW = 3'h4,
    GPPC_OD_HIGH = 3'h5,
    GPPC_STRONG = 3'h6,
    GPPC_WEAK = 3'h7
  } gppc_drive_e;
  typedef enum logic [1:0] {
    GPPC_SEL_SW = 2'h0,
    GPPC_SEL_P0 = 2'h1,
    GPPC_SEL_P1 = 2'h2,
    GPPC_SEL_OFF = 2'h3
  } gppc_sel_e;
  typedef enum logic [1:0] {
    GPPC_EDGE_NONE = 2'h0,
    GPPC_EDGE_RISE = 2'h1,
    GPPC_EDGE_FALL = 2'h2,
    GPPC_EDGE_BOTH = 2'h3
  } gppc_edge_e;
endpackage

// >>> gppc_top.sv
`timescale 1ns/1ps
`include "gppc_map.svh"
module gppc_top
  import gppc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [`GPPC_NUM_PINS-1:0] PAD_IN,
  output wire logic [`GPPC_NUM_PINS-1:0] PAD_OUT,
  output wire logic [`GPPC_NUM_PINS-1:0] PAD_OE,
  output wire logic [3*`GPPC_NUM_PINS-1:0] PAD_MODE,
  output wire logic [`GPPC_NUM_PINS-1:0] PAD_VTTL,
  output wire logic [`GPPC_NUM_PINS-1:0] PAD_SLOW,
  input wire logic [`GPPC_NUM_PINS-1:0] P0_OUT,
  input wire logic [`GPPC_NUM_PINS-1:0] P0_OE,
  input wire logic [`GPPC_NUM_PINS-1:0] P1_OUT,
  input wire logic [`GPPC_NUM_PINS-1:0] P1_OE,
  output wire logic [`GPPC_NUM_PINS-1:0] PERIPH_IN,
  output wire logic [`GPPC_NUM_PORTS-1:0] PORT_IRQ,
  output logic IRQ
);
  localparam int NP = `GPPC_NUM_PINS;
  localparam int NR = `GPPC_NUM_PORTS;
  localparam int NB = NR * 8;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic req;
  logic wr;
  logic rd;
  logic glb;
  logic [3:0] pidx;
  logic [3:0] ridx;
  logic [31:0] rmux;
  assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr = req & WB_WE_I;
  assign rd = req & ~WB_WE_I;
  assign glb = WB_ADR_I[`GPPC_GLB_BIT];
  assign pidx = WB_ADR_I[9:6];
  assign ridx = WB_ADR_I[5:2];

  logic [7:0] out_r [NR];
  logic [7:0] thr_r [NR];
  logic [7:0] slew_r [NR];
  logic [7:0] ien_r [NR];
  logic [7:0] pend_r [NR];
  logic [23:0] mode_r [NR];
  logic [15:0] sel_r [NR];
  logic [15:0] edge_r [NR];
  logic hold_r;
  logic [NR-1:0] stat_r;
  logic [NR-1:0] mask_r;
  wire [NB-1:0] pst;
  wire [NB-1:0] ev;
  wire [NR-1:0] pirq;

  // ------------------------------------------------------------
  // Global registers and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      hold_r <= 1'b0;
      mask_r <= '0;
    end else if (wr && glb && WB_SEL_I[0]) begin
      if (ridx == `GPPC_IDX_HOLD) begin
        hold_r <= WB_DAT_I[0];
      end
      if (ridx == `GPPC_IDX_MASK) begin
        mask_r <= WB_DAT_I[NR-1:0];
      end
    end
  end

  // Read clears, but a request in the same cycle still lands
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      stat_r <= '0;
    end else if (rd && glb && ridx == `GPPC_IDX_STAT) begin
      stat_r <= pirq;
    end else begin
      stat_r <= stat_r | pirq;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(stat_r & mask_r);
    end
  end

  // ------------------------------------------------------------
  // Per-port registers
  // ------------------------------------------------------------
  genvar p;
  for (p = 0; p < NR; p++) begin : g_port
    logic hit;
    logic [7:0] clr;
    logic irq;
    assign hit = wr && !glb && pidx == 4'(p);
    assign clr = (hit && ridx == `GPPC_IDX_PEND && WB_SEL_I[0]) ?
                 WB_DAT_I[7:0] : 8'h00;
    // Byte-wide software registers of this port
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        out_r[p] <= 8'h00;
        thr_r[p] <= 8'h00;
        slew_r[p] <= 8'h00;
        ien_r[p] <= 8'h00;
      end else if (hit && WB_SEL_I[0]) begin
        case (ridx)
          `GPPC_IDX_OUT: out_r[p] <= WB_DAT_I[7:0];
          `GPPC_IDX_THR: thr_r[p] <= WB_DAT_I[7:0];
          `GPPC_IDX_SLEW: slew_r[p] <= WB_DAT_I[7:0];
          `GPPC_IDX_IEN: ien_r[p] <= WB_DAT_I[7:0];
          default: ;
        endcase
      end
    end
    // Multi-lane fields honour each byte enable
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        mode_r[p] <= {8{`GPPC_RST_MODE}};
        sel_r[p] <= {8{`GPPC_RST_SEL}};
        edge_r[p] <= {8{`GPPC_RST_EDGE}};
      end else if (hit) begin
        for (int k = 0; k < 3; k++) begin
          if (WB_SEL_I[k] && ridx == `GPPC_IDX_MODE) begin
            mode_r[p][k*8+:8] <= WB_DAT_I[k*8+:8];
          end
        end
        for (int k = 0; k < 2; k++) begin
          if (WB_SEL_I[k] && ridx == `GPPC_IDX_SEL) begin
            sel_r[p][k*8+:8] <= WB_DAT_I[k*8+:8];
          end
          if (WB_SEL_I[k] && ridx == `GPPC_IDX_EDGE) begin
            edge_r[p][k*8+:8] <= WB_DAT_I[k*8+:8];
          end
        end
      end
    end
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        pend_r[p] <= 8'h00;
      end else begin
        pend_r[p] <= (pend_r[p] & ~clr) | ev[p*8+:8];
      end
    end
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        irq <= 1'b0;
      end else begin
        irq <= |(pend_r[p] & ien_r[p]);
      end
    end
    assign pirq[p] = irq;
    assign PORT_IRQ[p] = irq;
  end

  // ------------------------------------------------------------
  // Per-pin input path and pad drive
  // ------------------------------------------------------------
  genvar i;
  for (i = 0; i < NB; i++) begin : g_pin
    if (i < NP) begin : g_real
      localparam int P = i / 8;
      localparam int B = i % 8;
      logic s1;
      logic s2;
      logic s3;
      logic f;
      logic fd;
      logic d;
      logic en;
      logic oe;
      logic [2:0] md;
      logic o_r;
      logic oe_r;
      logic [2:0] m_r;
      logic v_r;
      logic sl_r;
      logic pin_r;
      gppc_sel_e src;
      gppc_edge_e eg;
      // Glitch filter: a change counts once two stages agree
      always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          f <= 1'b0;
          fd <= 1'b0;
        end else begin
          s1 <= PAD_IN[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            f <= s3;
          end
          fd <= f;
        end
      end
      // Input buffer is off in analog mode, so state reads low
      assign pst[i] = f & (m_r != GPPC_ANALOG);
      assign eg = gppc_edge_e'(edge_r[P][2*B+:2]);
      assign ev[i] = ien_r[P][B] &
                     ((eg[0] & f & ~fd) | (eg[1] & ~f & fd));
      assign src = gppc_sel_e'(sel_r[P][2*B+:2]);
      always_comb begin
        d = 1'b0;
        en = 1'b0;
        md = mode_r[P][3*B+:3];
        case (src)
          GPPC_SEL_SW: begin
            d = out_r[P][B];
            en = 1'b1;
          end
          GPPC_SEL_P0: begin
            d = P0_OUT[i];
            en = P0_OE[i];
          end
          GPPC_SEL_P1: begin
            d = P1_OUT[i];
            en = P1_OE[i];
          end
          default: md = GPPC_ANALOG;
        endcase
        case (gppc_drive_e'(md))
          GPPC_ANALOG: oe = 1'b0;
          GPPC_INPUT: oe = 1'b0;
          GPPC_OD_LOW: oe = en & ~d;
          GPPC_OD_HIGH: oe = en & d;
          default: oe = en;
        endcase
      end
      always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
          o_r <= 1'b0;
          oe_r <= 1'b0;
          m_r <= `GPPC_RST_MODE;
          v_r <= 1'b0;
          sl_r <= 1'b0;
        end else if (!hold_r) begin
          o_r <= d;
          oe_r <= oe;
          m_r <= md;
          v_r <= thr_r[P][B];
          sl_r <= slew_r[P][B];
        end
      end
      // Peripheral input only when a peripheral owns the pin
      always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
          pin_r <= 1'b0;
        end else begin
          pin_r <= pst[i] & (src == GPPC_SEL_P0 || src == GPPC_SEL_P1);
        end
      end
      assign PAD_OUT[i] = o_r;
      assign PAD_OE[i] = oe_r;
      assign PAD_MODE[3*i+:3] = m_r;
      assign PAD_VTTL[i] = v_r;
      assign PAD_SLOW[i] = sl_r;
      assign PERIPH_IN[i] = pin_r;
    end else begin : g_none
      assign pst[i] = 1'b0;
      assign ev[i] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read mux and answer
  // ------------------------------------------------------------
  always_comb begin
    rmux = 32'h0;
    if (glb) begin
      case (ridx)
        `GPPC_IDX_HOLD: rmux[0] = hold_r;
        `GPPC_IDX_STAT: rmux[NR-1:0] = stat_r;
        `GPPC_IDX_MASK: rmux[NR-1:0] = mask_r;
        default: ;
      endcase
    end else if (pidx < 4'(NR)) begin
      case (ridx)
        `GPPC_IDX_OUT: rmux[7:0] = out_r[pidx];
        `GPPC_IDX_IN: rmux[7:0] = pst[{pidx, 3'b000}+:8];
        `GPPC_IDX_MODE: rmux[23:0] = mode_r[pidx];
        `GPPC_IDX_THR: rmux[7:0] = thr_r[pidx];
        `GPPC_IDX_SLEW: rmux[7:0] = slew_r[pidx];
        `GPPC_IDX_SEL: rmux[15:0] = sel_r[pidx];
        `GPPC_IDX_EDGE: rmux[15:0] = edge_r[pidx];
        `GPPC_IDX_IEN: rmux[7:0] = ien_r[pidx];
        `GPPC_IDX_PEND: rmux[7:0] = pend_r[pidx];
        default: ;
      endcase
    end
  end

  // Every access answers after one cycle, unmapped reads give zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= req;
      if (rd) begin
        WB_DAT_O <= rmux;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_grp;
    @(posedge SYS_CLK) disable iff (RESET)
    (wr && !glb && pidx == 4'h1 && ridx == `GPPC_IDX_OUT && WB_SEL_I[0])
    |=> out_r[1] == $past(WB_DAT_I[7:0]);
  endproperty
  a_grp: assert property (p_grp) else $error("port write missed");

  property p_odl;
    @(posedge SYS_CLK) disable iff (RESET)
    (!hold_r && mode_r[0][2:0] == GPPC_OD_LOW &&
     sel_r[0][1:0] == GPPC_SEL_SW && !out_r[0][0]) |=> PAD_OE[0];
  endproperty
  a_odl: assert property (p_odl) else $error("open drain low off");

  property p_ana;
    @(posedge SYS_CLK) disable iff (RESET)
    ((!hold_r && mode_r[0][2:0] == GPPC_ANALOG) [*2]) |=>
    !PAD_OE[0] && !pst[0];
  endproperty
  a_ana: assert property (p_ana) else $error("analog pin driven");

  property p_thr;
    @(posedge SYS_CLK) disable iff (RESET)
    !hold_r |=> PAD_VTTL[0] == $past(thr_r[0][0]);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold not applied");

  property p_hold;
    @(posedge SYS_CLK) disable iff (RESET)
    hold_r |=> $stable(PAD_OUT) && $stable(PAD_OE) && $stable(PAD_MODE);
  endproperty
  a_hold: assert property (p_hold) else $error("pad moved in hold");

  property p_slew;
    @(posedge SYS_CLK) disable iff (RESET)
    !hold_r |=> PAD_SLOW[5] == $past(slew_r[0][5]);
  endproperty
  a_slew: assert property (p_slew) else $error("slew not applied");

  property p_rst;
    @(posedge SYS_CLK)
    RESET |=> PAD_OE == '0 && PAD_MODE == '0 && !IRQ;
  endproperty
  a_rst: assert property (p_rst) else $error("pin live in reset");

  property p_mux;
    @(posedge SYS_CLK) disable iff (RESET)
    (!hold_r && sel_r[0][1:0] == GPPC_SEL_P0) |=>
    PAD_OUT[0] == $past(P0_OUT[0]);
  endproperty
  a_mux: assert property (p_mux) else $error("matrix source wrong");

  property p_pin;
    @(posedge SYS_CLK) disable iff (RESET)
    (!RESET && PAD_IN[0]) [*4] |=> g_pin[0].g_real.f;
  endproperty
  a_pin: assert property (p_pin) else $error("pin state late");

  property p_pirq;
    @(posedge SYS_CLK) disable iff (RESET)
    (|(pend_r[2] & ien_r[2])) |=> PORT_IRQ[2];
  endproperty
  a_pirq: assert property (p_pirq) else $error("port request lost");

  property p_ien;
    @(posedge SYS_CLK) disable iff (RESET)
    (!ien_r[1][1] && !pend_r[1][1]) |=> !pend_r[1][1];
  endproperty
  a_ien: assert property (p_ien) else $error("disabled pin flagged");

  property p_w1c;
    @(posedge SYS_CLK) disable iff (RESET)
    (g_port[1].clr[0] && !ev[8]) |=> !pend_r[1][0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_set;
    @(posedge SYS_CLK) disable iff (RESET)
    ev[8] |=> pend_r[1][0] ##1 (PORT_IRQ[1] || !ien_r[1][0]);
  endproperty
  a_set: assert property (p_set) else $error("edge event lost");

  property p_ack;
    @(posedge SYS_CLK) disable iff (RESET)
    req |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer wrong");

  c_irq: cover property (@(posedge SYS_CLK) disable iff (RESET) $rose(IRQ));
  c_hold: cover property (@(posedge SYS_CLK) disable iff (RESET)
    $rose(hold_r));
  c_odh: cover property (@(posedge SYS_CLK) disable iff (RESET)
    PAD_MODE[17:15] == GPPC_OD_HIGH && PAD_OE[5]);
endmodule

// >>> gppc_board.sv
`timescale 1ns/1ps
`include "gppc_map.svh"
module gppc_board (
  input wire logic [`GPPC_NUM_PINS-1:0] pad_out,
  input wire logic [`GPPC_NUM_PINS-1:0] pad_oe,
  input wire logic [`GPPC_NUM_PINS-1:0] ext_en,
  input wire logic [`GPPC_NUM_PINS-1:0] ext_val,
  output logic [`GPPC_NUM_PINS-1:0] pad_in
);
  // ----------------------------------------
  // Board wiring
  // ----------------------------------------
  // Pull-up on every line, so a released pin never keeps its last level
  always_comb begin
    pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
      | (~pad_oe & ~ext_en);
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`include "gppc_map.svh"
module tb_top
  import gppc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic ack;
  logic irq;
  logic [9:0] port_irq;
  logic [233:0] mode;
  logic [77:0] pad_in, pad_out, pad_oe, vttl, slow, pin;
  logic [77:0] p0_out = '0;
  logic [77:0] p0_oe = '0;
  logic [77:0] p1_out = '0;
  logic [77:0] p1_oe = '0;
  logic [77:0] ext_en = '0;
  logic [77:0] ext_val = '0;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  int e;

  always #10 clk = ~clk;

  gppc_top u_dut (.SYS_CLK(clk), .RESET(rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PAD_IN(pad_in),
    .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_MODE(mode), .PAD_VTTL(vttl),
    .PAD_SLOW(slow), .P0_OUT(p0_out), .P0_OE(p0_oe), .P1_OUT(p1_out),
    .P1_OE(p1_oe), .PERIPH_IN(pin), .PORT_IRQ(port_irq), .IRQ(irq));

  gppc_board u_board (.pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) chk("ack", 32'h1, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input string nm,
    input logic [31:0] ex);
    wb(1'b0, a, 32'h0);
    chk(nm, ex, q);
  endtask

  // Off the edge, so outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    wt(8);
    chk("oe_rst", 32'h0, {31'h0, |pad_oe});
    chk("mode_rst", 32'h0, {31'h0, |mode});
    @(posedge clk);
    rst <= 1'b0;
    // Pin i of port 0 gets drive code i
    wb(1'b1, 12'h008, 32'hfac688);
    wb(1'b1, 12'h000, 32'ha5);
    wt(2);
    chk("mode0", 32'hfac688, {8'h0, mode[23:0]});
    chk("oe0", 32'h70, {24'h0, pad_oe[7:0] & 8'h73});
    chk("out0", 32'h20, {24'h0, pad_out[7:0] & 8'h70});
    wb(1'b1, 12'h000, 32'h5a);
    wb(1'b1, 12'h00c, 32'h0f);
    wb(1'b1, 12'h010, 32'hf0);
    wt(2);
    chk("oe0b", 32'h40, {24'h0, pad_oe[7:0] & 8'h73});
    chk("vttl", 32'h0f, {24'h0, vttl[7:0]});
    chk("slow", 32'hf0, {24'h0, slow[7:0]});
    // Changes while held must not reach the pads
    wb(1'b1, 12'h800, 32'h1);
    wb(1'b1, 12'h000, 32'ha5);
    wb(1'b1, 12'h00c, 32'h0);
    wt(3);
    chk("hold_oe", 32'h40, {24'h0, pad_oe[7:0] & 8'h73});
    chk("hold_vttl", 32'h0f, {24'h0, vttl[7:0]});
    wb(1'b1, 12'h800, 32'h0);
    wt(2);
    chk("free_oe", 32'h70, {24'h0, pad_oe[7:0] & 8'h73});
    chk("free_vttl", 32'h0, {24'h0, vttl[7:0]});
    // Pin 6 from peripheral 0, pin 7 switched off
    @(posedge clk);
    p0_oe <= '1;
    p0_out <= 78'h40;
    wb(1'b1, 12'h014, 32'hd000);
    wt(12);
    chk("sel_out", 32'h1, {31'h0, pad_out[6]});
    chk("sel_off", 32'h0, {29'h0, mode[23:21]});
    chk("periph", 32'h40, {24'h0, pin[7:0]});
    @(posedge clk);
    p0_out <= '0;
    wt(12);
    chk("sel_out0", 32'h0, {31'h0, pad_out[6]});
    chk("periph0", 32'h0, {24'h0, pin[7:0]});
    // Pin 6 handed to peripheral 1
    @(posedge clk);
    p1_oe <= '1;
    p1_out <= 78'h40;
    wb(1'b1, 12'h014, 32'he000);
    wt(12);
    chk("sel_p1", 32'h1, {31'h0, pad_out[6]});
    chk("periph1", 32'h40, {24'h0, pin[7:0]});
    // Port 1 as inputs, port 2 left analog
    @(posedge clk);
    ext_en <= '1;
    ext_val <= 78'hff3c00;
    wb(1'b1, 12'h048, 32'h249249);
    wt(12);
    rd(12'h044, "in1", 32'h3c);
    rd(12'h084, "in2", 32'h0);
    // Pin 8 enabled, pin 9 not but on both edges; every edge code
    wb(1'b1, 12'h05c, 32'h1);
    for (e = 0; e < 4; e++) begin
      wb(1'b1, 12'h058, 32'(e) | 32'hc);
      @(posedge clk);
      ext_val[9:8] <= 2'b11;
      wt(12);
      rd(12'h060, "pend_r", 32'(e & 1));
      chk("pirq_r", 32'(e & 1), {31'h0, port_irq[1]});
      wb(1'b1, 12'h060, 32'h3);
      @(posedge clk);
      ext_val[9:8] <= 2'b00;
      wt(12);
      rd(12'h060, "pend_f", 32'((e >> 1) & 1));
      wb(1'b1, 12'h060, 32'h3);
    end
    wb(1'b1, 12'h058, 32'h1);
    @(posedge clk);
    ext_val[8] <= 1'b1;
    wt(12);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wb(1'b1, 12'h808, 32'h2);
    wt(3);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, 12'h060, 32'h1);
    wt(3);
    rd(12'h804, "stat", 32'h2);
    wt(3);
    rd(12'h804, "stat_clr", 32'h0);
    wt(3);
    chk("irq_off", 32'h0, {31'h0, irq});
    // Last port is partial: pins 72..77
    wb(1'b1, 12'h248, 32'hdb6db6);
    wb(1'b1, 12'h240, 32'hff);
    wt(2);
    chk("p9_oe", 32'h3f, {26'h0, pad_oe[77:72]});
    chk("p9_out", 32'h3f, {26'h0, pad_out[77:72]});
    rd(12'h280, "port10", 32'h0);
    rd(12'h80c, "unmapped", 32'h0);
    // Reset in mid-run disables the pins again
    @(posedge clk);
    rst <= 1'b1;
    wt(2);
    chk("oe_rst2", 32'h0, {31'h0, |pad_oe});
    chk("mode_rst2", 32'h0, {31'h0, |mode});
    @(posedge clk);
    rst <= 1'b0;
    rd(12'h058, "edge_rst", 32'h5555);
    rd(12'h000, "out_rst", 32'h0);
    chk("oe_rst3", 32'h0, {31'h0, |pad_oe});
    results();
  end
endmodule
